// *** hw/osc_pkg.sv ***
// Purpose: shared constants and types of the oscillator select control
// Assumes: 125 MHz sys_clk, AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses of aligned words
package osc_pkg;

  // bus geometry
  localparam int          AXI_ADDR_W      = 8;
  localparam int          AXI_DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // register byte offsets
  localparam logic [7:0]  OFS_CONTROL     = 8'h00;
  localparam logic [7:0]  OFS_UNLOCK      = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  OFS_ACTIVE      = 8'h10;

  // control field positions
  localparam int          POS_SWITCH_REQ  = 0;
  localparam int          POS_LF_ENABLE   = 1;
  localparam int          POS_CLK_FAIL    = 3;
  localparam int          POS_SLEEP_SEL   = 4;
  localparam int          POS_SEL_LOCK    = 7;
  localparam int          POS_NEW_SRC     = 8;

  // unlock keys, values arbitrary
  localparam logic [31:0] UNLOCK_KEY_A    = 32'h0000C35A;
  localparam logic [31:0] UNLOCK_KEY_B    = 32'h00003CA5;

  // source codes
  localparam logic [2:0]  SRC_FAST_RC     = 3'h0;
  localparam logic [2:0]  SRC_SYSTEM_PLL  = 3'h1;
  localparam logic [2:0]  SRC_PRIMARY     = 3'h2;
  localparam logic [2:0]  SRC_RESERVED    = 3'h3;
  localparam logic [2:0]  SRC_SECONDARY   = 3'h4;
  localparam logic [2:0]  SRC_LOW_POWER   = 3'h5;

  // interrupt event bits
  localparam int          IRQ_W           = 3;
  localparam int          EVT_SWITCH_DONE = 0;
  localparam int          EVT_CLOCK_FAIL  = 1;
  localparam int          EVT_WRITE_REJ   = 2;

  // reset values of software state
  localparam logic [2:0]  RST_IRQ         = 3'h0;
  localparam logic [2:0]  RST_SOURCE      = 3'h0;

  // fail-safe monitor timing
  localparam int          CLK_PERIOD_PS   = 8000;
  localparam int          FAIL_TIME_NS    = 8000;
  localparam int          FAIL_CYCLES     =
    (FAIL_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int          FAIL_CNT_W      = 11;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_REQ  = 3'b010,
    SW_DONE = 3'b100
  } osc_sw_state_t;

  // boot configuration word
  typedef struct packed {
    logic       twoSpeedStartupConfig;
    logic       lowFreqOscEnable;
    logic [2:0] reserved;
    logic [2:0] configSourceSelect;
  } osc_cfg_t;

  // control register view
  typedef struct packed {
    logic [20:0] reservedHigh;
    logic [2:0]  newSourceSelect;
    logic        selectionLock;
    logic [1:0]  reservedA;
    logic        sleepOnWaitSelect;
    logic        clockFailFlag;
    logic        reservedB;
    logic        lowFreqOscEnable;
    logic        switchRequest;
  } osc_ctrl_t;

endpackage

// *** hw/osc_fail_monitor.sv ***
// Purpose: fail-safe clock monitor, watches heartbeat of active source
// Assumes: heartbeat tick synchronous to sys_clk
// Notes:   one failPulse per silence, rearmed by the next tick
`timescale 1ns/1ps
module osc_fail_monitor #(
  parameter int TIMEOUT = 1000,
  parameter int CNT_W   = 11
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic heartbeat,
  output logic      failPulse
);

  logic [CNT_W-1:0] silentCount;
  logic             tripped;

  // silence counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      silentCount <= '0;
    end else if (!enable || heartbeat) begin
      silentCount <= '0;
    end else if (!tripped) begin
      silentCount <= silentCount + 1'b1;
    end
  end

  // trip once per silence
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tripped   <= 1'b0;
      failPulse <= 1'b0;
    end else begin
      failPulse <= 1'b0;
      if (!enable || heartbeat) begin
        tripped <= 1'b0;
      end else if (!tripped &&
                   silentCount == CNT_W'(TIMEOUT - 1)) begin
        tripped   <= 1'b1;
        failPulse <= 1'b1;
      end
    end
  end

endmodule // osc_fail_monitor

// *** hw/osc_select_control.sv ***
// Purpose: oscillator selection control register and switch sequencing
// Assumes: config word stable at reset release; inputs synchronous
// Notes:   AXI4-Lite slave, one write and one read in flight
//
// What this block does
// - new-source codes pick fast RC, PLL, primary, secondary, low-power RC
// - codes 110 and 111 act as fast RC; code 011 is reserved
// - new-source field loads from config source select after reset
// - selection lock set freezes new-source select and switch request
// - bits 6, 5 and 2 always read zero
// - wait instruction enters Sleep if sleep select set, else Idle
// - clock-fail flag set when fail-safe monitor sees a failure
// - low-frequency enable bit turns the secondary oscillator on or off
// - low-frequency enable resets to its config word bit
// - writing 1 to switch request starts a switch; cleared when done
// - switch request resets to the two-speed start-up config bit
// - control writes accepted only after the unlock sequence
`timescale 1ns/1ps
module osc_select_control (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // axi4-lite slave
  input  wire logic [osc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [osc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [osc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [osc_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // boot configuration and clock system
  input  wire osc_pkg::osc_cfg_t             oscillatorConfigWord,
  input  wire logic                          activeOscTick,
  input  wire logic                          switchDone,
  input  wire logic                          waitExecuted,
  output logic [2:0]                         activeSource,
  output logic [2:0]                         targetSource,
  output logic                               switchGo,
  output logic                               lowFreqOscEnable,
  output logic                               enterSleep,
  output logic                               enterIdle,
  output logic                               irq
);
  import osc_pkg::*;

  // control state
  logic [2:0]    newSourceSelect;
  logic          selectionLock;
  logic          sleepOnWaitSelect;
  logic          clockFailFlag;
  logic          switchRequest;
  logic          cfgLoaded;
  logic [1:0]    unlockStage;
  logic [2:0]    irqStatus;
  logic [2:0]    irqMask;
  osc_sw_state_t swState;
  osc_sw_state_t next_swState;

  // bus state
  logic [7:0]    awAddrHeld;
  logic          awHeld;
  logic [31:0]   wDataHeld;
  logic [3:0]    wStrbHeld;
  logic          wHeld;

  // decoded strobes
  logic          doWrite;
  logic          ctrlWr;
  logic          unlocked;
  logic          ctrlAccepted;
  logic          wrLane0;
  logic          wrLane1;
  logic          swSetRequest;
  logic          swNewSource;
  logic          hwClearRequest;
  logic          failPulse;
  logic          isReserved;
  logic [2:0]    irqEvents;
  logic [2:0]    irqClear;
  osc_ctrl_t     ctrlView;

  // target decode
  function automatic logic [2:0] decodeSource(input logic [2:0] code);
    case (code)
      SRC_SYSTEM_PLL: decodeSource = SRC_SYSTEM_PLL;
      SRC_PRIMARY:    decodeSource = SRC_PRIMARY;
      SRC_SECONDARY:  decodeSource = SRC_SECONDARY;
      SRC_LOW_POWER:  decodeSource = SRC_LOW_POWER;
      default:        decodeSource = SRC_FAST_RC;
    endcase
  endfunction

  assign targetSource = decodeSource(newSourceSelect);
  assign isReserved   = (newSourceSelect == SRC_RESERVED);

  // ---------------- axi write channel ----------------
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      awHeld     <= 1'b0;
      awAddrHeld <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld     <= 1'b1;
      awAddrHeld <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld     <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wHeld     <= 1'b0;
      wDataHeld <= 32'h00000000;
      wStrbHeld <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld     <= 1'b1;
      wDataHeld <= s_axi_wdata;
      wStrbHeld <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld     <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      case (awAddrHeld[7:2])
        OFS_CONTROL[7:2], OFS_UNLOCK[7:2], OFS_IRQ_STATUS[7:2],
        OFS_IRQ_MASK[7:2], OFS_ACTIVE[7:2]: s_axi_bresp <= RESP_OKAY;
        default:                             s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // write decode
  assign ctrlWr       = doWrite && (awAddrHeld[7:2] == OFS_CONTROL[7:2]);
  assign unlocked     = (unlockStage == 2'h2);
  assign ctrlAccepted = ctrlWr && unlocked && cfgLoaded;
  assign wrLane0      = ctrlAccepted && wStrbHeld[0];
  assign wrLane1      = ctrlAccepted && wStrbHeld[1];
  assign swSetRequest = wrLane0 && !selectionLock &&
                        wDataHeld[POS_SWITCH_REQ];
  assign swNewSource  = wrLane1 && !selectionLock;

  // unlock sequence, cleared by any control write
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      unlockStage <= 2'h0;
    end else if (ctrlWr) begin
      unlockStage <= 2'h0;
    end else if (doWrite && awAddrHeld[7:2] == OFS_UNLOCK[7:2]) begin
      if (wDataHeld == UNLOCK_KEY_A) begin
        unlockStage <= 2'h1;
      end else if (wDataHeld == UNLOCK_KEY_B && unlockStage == 2'h1) begin
        unlockStage <= 2'h2;
      end else begin
        unlockStage <= 2'h0;
      end
    end
  end

  // config capture once after reset release
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfgLoaded <= 1'b0;
    end else begin
      cfgLoaded <= 1'b1;
    end
  end

  // ---------------- control fields ----------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      newSourceSelect <= RST_SOURCE;
    end else if (!cfgLoaded) begin
      newSourceSelect <= oscillatorConfigWord.configSourceSelect;
    end else if (swNewSource) begin
      newSourceSelect <= wDataHeld[POS_NEW_SRC +: 3];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      selectionLock <= 1'b0;
    end else if (wrLane0 && wDataHeld[POS_SEL_LOCK]) begin
      selectionLock <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sleepOnWaitSelect <= 1'b0;
    end else if (wrLane0) begin
      sleepOnWaitSelect <= wDataHeld[POS_SLEEP_SEL];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lowFreqOscEnable <= 1'b0;
    end else if (!cfgLoaded) begin
      lowFreqOscEnable <= oscillatorConfigWord.lowFreqOscEnable;
    end else if (wrLane0) begin
      lowFreqOscEnable <= wDataHeld[POS_LF_ENABLE];
    end
  end

  // clock-fail flag, monitor set beats software clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clockFailFlag <= 1'b0;
    end else if (failPulse) begin
      clockFailFlag <= 1'b1;
    end else if (wrLane0 && !wDataHeld[POS_CLK_FAIL]) begin
      clockFailFlag <= 1'b0;
    end
  end

  // switch request, software set beats hardware clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      switchRequest <= 1'b0;
    end else if (!cfgLoaded) begin
      switchRequest <= oscillatorConfigWord.twoSpeedStartupConfig;
    end else if (swSetRequest) begin
      switchRequest <= 1'b1;
    end else if (hwClearRequest) begin
      switchRequest <= 1'b0;
    end
  end

  // ---------------- switch sequencer ----------------
  always_comb begin
    next_swState = swState;
    case (swState)
      SW_IDLE: begin
        if (cfgLoaded && switchRequest && !failPulse) begin
          next_swState = isReserved ? SW_DONE : SW_REQ;
        end
      end
      SW_REQ: begin
        if (failPulse) begin
          next_swState = SW_IDLE;
        end else if (switchDone) begin
          next_swState = SW_DONE;
        end
      end
      SW_DONE: next_swState = SW_IDLE;
      default: next_swState = SW_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      swState <= SW_IDLE;
    end else begin
      swState <= next_swState;
    end
  end

  assign switchGo       = (swState == SW_REQ);
  assign hwClearRequest = (swState == SW_DONE) ||
                          (swState == SW_REQ && failPulse);

  // active source, fail forces fast RC
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      activeSource <= SRC_FAST_RC;
    end else if (failPulse) begin
      activeSource <= SRC_FAST_RC;
    end else if (swState == SW_DONE && !isReserved) begin
      activeSource <= targetSource;
    end
  end

  osc_fail_monitor #(
    .TIMEOUT (FAIL_CYCLES),
    .CNT_W   (FAIL_CNT_W)
  ) u_fail_monitor (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .enable    (cfgLoaded && swState == SW_IDLE),
    .heartbeat (activeOscTick),
    .failPulse (failPulse)
  );

  // wait instruction power mode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enterSleep <= 1'b0;
      enterIdle  <= 1'b0;
    end else begin
      enterSleep <= waitExecuted && sleepOnWaitSelect;
      enterIdle  <= waitExecuted && !sleepOnWaitSelect;
    end
  end

  // ---------------- interrupts ----------------
  assign irqEvents[EVT_SWITCH_DONE] = (swState == SW_DONE);
  assign irqEvents[EVT_CLOCK_FAIL]  = failPulse;
  assign irqEvents[EVT_WRITE_REJ]   = ctrlWr && !unlocked;
  assign irqClear = (doWrite && wStrbHeld[0] &&
                     awAddrHeld[7:2] == OFS_IRQ_STATUS[7:2]) ?
                    wDataHeld[IRQ_W-1:0] : 3'h0;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqStatus <= RST_IRQ;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqMask <= RST_IRQ;
    end else if (doWrite && wStrbHeld[0] &&
                 awAddrHeld[7:2] == OFS_IRQ_MASK[7:2]) begin
      irqMask <= wDataHeld[IRQ_W-1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ---------------- axi read channel ----------------
  always_comb begin
    ctrlView                   = '0;
    ctrlView.newSourceSelect   = newSourceSelect;
    ctrlView.selectionLock     = selectionLock;
    ctrlView.sleepOnWaitSelect = sleepOnWaitSelect;
    ctrlView.clockFailFlag     = clockFailFlag;
    ctrlView.lowFreqOscEnable  = lowFreqOscEnable;
    ctrlView.switchRequest     = switchRequest;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr[7:2])
        OFS_CONTROL[7:2]:    s_axi_rdata <= ctrlView;
        OFS_UNLOCK[7:2]:     s_axi_rdata <= {30'h0, unlockStage};
        OFS_IRQ_STATUS[7:2]: s_axi_rdata <= {29'h0, irqStatus};
        OFS_IRQ_MASK[7:2]:   s_axi_rdata <= {29'h0, irqMask};
        OFS_ACTIVE[7:2]:     s_axi_rdata <= {28'h0, switchGo, activeSource};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // osc_select_control

// *** sim/osc_select_control_checker.sv ***
// Purpose: port-level checks of the oscillator select control
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound to every osc_select_control instance
`timescale 1ns/1ps
module osc_select_control_checker (
  input wire logic                           sys_clk,
  input wire logic                           reset,
  input wire logic [osc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic [osc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic                           s_axi_rvalid,
  input wire osc_pkg::osc_cfg_t              oscillatorConfigWord,
  input wire logic                           switchDone,
  input wire logic                           waitExecuted,
  input wire logic [2:0]                     activeSource,
  input wire logic [2:0]                     targetSource,
  input wire logic                           switchGo,
  input wire logic                           lowFreqOscEnable,
  input wire logic                           enterSleep,
  input wire logic                           enterIdle
);
  import osc_pkg::*;
  logic [7:0] lastAddr;
  logic [1:0] sinceRst;
  logic [2:0] cfgSrc;
  assign cfgSrc = oscillatorConfigWord.configSourceSelect;
  // address of the read in flight
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) lastAddr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) lastAddr <= s_axi_araddr;
  end
  // edges since reset release, saturating
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) sinceRst <= 2'h0;
    else if (sinceRst != 2'h3) sinceRst <= sinceRst + 2'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wait_mode_pulse_a: assert property (
    waitExecuted |=> enterSleep ^ enterIdle)
    else $error("wait gave no single mode pulse");
  wait_mode_cause_a: assert property (
    (enterSleep || enterIdle) |-> $past(waitExecuted))
    else $error("mode pulse without wait");
  target_code_a: assert property (
    targetSource inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
    else $error("target source code not decoded");
  switch_finish_a: assert property (
    switchGo && switchDone |->
    ##[1:2] (!switchGo && activeSource == targetSource))
    else $error("switch did not finish");
  switch_hold_a: assert property (switchGo && !switchDone |=> switchGo)
    else $error("switch request dropped early");
  active_cause_a: assert property (
    $changed(activeSource) |-> $past(switchGo) || $past(switchGo, 2) ||
    activeSource == SRC_FAST_RC) else $error("active source moved");
  read_zero_a: assert property (
    s_axi_rvalid && lastAddr == OFS_CONTROL |-> s_axi_rdata[6:5] == 2'h0 &&
    !s_axi_rdata[2] && s_axi_rdata[31:11] == 21'h0)
    else $error("unimplemented control bits not zero");
  reset_load_a: assert property (
    sinceRst == 2'h1 |->
    lowFreqOscEnable == oscillatorConfigWord.lowFreqOscEnable &&
    targetSource == ((cfgSrc == 3'h3 || cfgSrc > 3'h5) ? 3'h0 : cfgSrc))
    else $error("reset load wrong");
  startup_switch_a: assert property (
    sinceRst == 2'h1 |->
    ##[0:2] switchGo == oscillatorConfigWord.twoSpeedStartupConfig)
    else $error("start-up switch");
  cover property (switchGo && switchDone);
  cover property (enterSleep);
  cover property (enterIdle);
  cover property (sinceRst == 2'h1 &&
    oscillatorConfigWord.twoSpeedStartupConfig);
endmodule // osc_select_control_checker

bind osc_select_control osc_select_control_checker
  osc_select_control_checker_inst (
  .sys_clk, .reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .oscillatorConfigWord, .switchDone,
  .waitExecuted, .activeSource, .targetSource, .switchGo,
  .lowFreqOscEnable, .enterSleep, .enterIdle);

// *** sim/osc_select_control_test.sv ***
// Purpose: self-checking bench for the oscillator select control
// Assumes: 125 MHz sys_clk, bench acts as AXI4-Lite master
// Notes:   random fields come from an lfsr with a fixed seed
`timescale 1ns/1ps
module osc_select_control_test;
  import osc_pkg::*;
  logic        sys_clk, awReady, wReady, bValid, arReady, rValid;
  logic        reset = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic        arValid = 1'b0, rReady = 1'b0, switchDone = 1'b0;
  logic        waitExec = 1'b0, tick = 1'b0, tickOn = 1'b1;
  logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0, rnd = 32'hF87F89DB, rData;
  logic [1:0]  bResp, rResp;
  osc_cfg_t    cfgWord = '0;
  logic [2:0]  activeSource, targetSource;
  logic        switchGo, lfEnable, enterSleep, enterIdle, irq;
  int          fails = 0, checksDone = 0;

  osc_select_control osc_select_control_inst (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .oscillatorConfigWord(cfgWord),
    .activeOscTick(tick), .switchDone(switchDone), .waitExecuted(waitExec),
    .activeSource(activeSource), .targetSource(targetSource),
    .switchGo(switchGo), .lowFreqOscEnable(lfEnable),
    .enterSleep(enterSleep), .enterIdle(enterIdle), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] dec(input logic [2:0] c);
    return (c == SRC_RESERVED || c > SRC_LOW_POWER) ? SRC_FAST_RC : c;
  endfunction
  function automatic logic [31:0] ctrlWord(input logic [2:0] s,
                                           input logic sl, lf, rq);
    return {21'h0, s, 3'h0, sl, 2'h0, lf, rq};
  endfunction

  // random heartbeat of the running oscillator
  always @(posedge sys_clk) begin
    rnd <= lfsr(rnd);
    tick <= tickOn && rnd[3:2] == 2'h0;
  end

  task automatic print_verdict;
    if (fails == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timedOut;
    check("handshake wait", 1'b0, 1'b1);
    print_verdict();
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] resp);
    logic awGo, wGo, bGo;
    @(posedge sys_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge sys_clk);
      awGo = awValid && awReady;
      wGo = wValid && wReady;
      bGo = bValid;
      resp = bResp;
      @(posedge sys_clk);
      if (awGo) awValid <= 1'b0;
      if (wGo) wValid <= 1'b0;
      if (bGo) begin
        bReady <= 1'b0;
        return;
      end
    end
    timedOut();
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] resp);
    logic arGo, rGo;
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge sys_clk);
      arGo = arValid && arReady;
      rGo = rValid;
      d = rData;
      resp = rResp;
      @(posedge sys_clk);
      if (arGo) arValid <= 1'b0;
      if (rGo) begin
        rReady <= 1'b0;
        return;
      end
    end
    timedOut();
  endtask
  task automatic ctrlWrite(input logic [31:0] d);
    logic [1:0] r;
    axiWrite(OFS_UNLOCK, UNLOCK_KEY_A, r);
    axiWrite(OFS_UNLOCK, UNLOCK_KEY_B, r);
    axiWrite(OFS_CONTROL, d, r);
    check("control write response", r, RESP_OKAY);
  endtask
  task automatic finishSwitch(input logic [2:0] src);
    int n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (switchGo !== 1'b1 && n < 16);
    check("switchGo", switchGo, 1'b1);
    check("targetSource", targetSource, src);
    @(posedge sys_clk);
    switchDone <= 1'b1;
    @(posedge sys_clk);
    switchDone <= 1'b0;
  endtask
  task automatic resetDut(input logic [7:0] cfg);
    logic [31:0] rd;
    logic [1:0]  r;
    @(posedge sys_clk);
    reset <= 1'b1;
    cfgWord <= osc_cfg_t'(cfg);
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("targetSource", targetSource, dec(cfg[2:0]));
    check("lowFreqOscEnable", lfEnable, cfg[6]);
    axiRead(OFS_CONTROL, rd, r);
    check("control", rd, ctrlWord(cfg[2:0], 1'b0, cfg[6], cfg[7]));
  endtask

  initial begin
    static logic [2:0] codes [8] =
      '{3'h0, 3'h6, 3'h1, 3'h7, 3'h2, 3'h4, 3'h3, 3'h5};
    logic [31:0] rd, rd2;
    logic [1:0]  r;
    logic [2:0]  act;
    logic        sl, lf;
    int          n;
    resetDut(8'hC2);
    finishSwitch(SRC_PRIMARY);
    axiRead(OFS_ACTIVE, rd, r);
    check("active", rd, 32'h2);
    resetDut(8'h05);
    act = SRC_FAST_RC;
    axiWrite(OFS_IRQ_MASK, 32'h3, r);
    axiWrite(OFS_CONTROL, 32'h101, r);
    axiRead(OFS_CONTROL, rd, r);
    check("locked control", rd, 32'h500);
    axiRead(OFS_IRQ_STATUS, rd, r);
    @(negedge sys_clk);
    check("irq masked", irq, 1'b0);
    check("irq status", rd, 32'h4);
    axiWrite(OFS_IRQ_MASK, 32'h7, r);
    @(negedge sys_clk);
    check("irq", irq, 1'b1);
    axiWrite(OFS_IRQ_STATUS, 32'h4, r);
    @(negedge sys_clk);
    check("irq cleared", irq, 1'b0);
    for (int i = 0; i < 8; i++) begin
      sl = rnd[5];
      lf = rnd[9];
      ctrlWrite({21'h0, codes[i], 3'h0, sl, 2'h0, lf, 1'b1});
      @(negedge sys_clk);
      check("lowFreqOscEnable", lfEnable, lf);
      if (codes[i] != SRC_RESERVED) begin
        finishSwitch(dec(codes[i]));
        act = dec(codes[i]);
      end
      axiRead(OFS_ACTIVE, rd, r);
      check("active", rd, {29'h0, act});
      check("activeSource", activeSource, act);
      axiRead(OFS_CONTROL, rd, r);
      check("control", rd, ctrlWord(codes[i], sl, lf, 1'b0));
      @(posedge sys_clk);
      waitExec <= 1'b1;
      @(posedge sys_clk);
      waitExec <= 1'b0;
      @(negedge sys_clk);
      check("enterSleep", enterSleep, sl);
      check("enterIdle", enterIdle, !sl);
      axiWrite(OFS_IRQ_STATUS, 32'h7, r);
    end
    axiRead(8'h20, rd, r);
    check("unmapped response", r, RESP_SLVERR);
    check("unmapped data", rd, 32'h0);
    @(posedge sys_clk);
    tickOn <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (irq !== 1'b1 && n < 1100);
    check("fail delay", n >= 995 && n <= 1010, 1'b1);
    tickOn <= 1'b1;
    axiRead(OFS_CONTROL, rd, r);
    check("clock fail flag", rd[3], 1'b1);
    axiRead(OFS_ACTIVE, rd2, r);
    check("active after fail", rd2, 32'h0);
    ctrlWrite((rd & 32'hFFFFFFFE) | 32'h80);
    ctrlWrite((rd & 32'hFFFFF8FE) | 32'h481);
    @(negedge sys_clk);
    check("switchGo locked", switchGo, 1'b0);
    axiRead(OFS_CONTROL, rd2, r);
    check("locked select", rd2[10:7], {rd[10:8], 1'b1});
    print_verdict();
  end
endmodule // osc_select_control_test
